// File: pkg/cthr_pkg.sv
package cthr_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACTIVE_CNT = 8'h08;
  localparam logic [7:0] OFS_HOLD_CNT = 8'h0C;

  // Control register field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_AFTER_BIT = 2;
  localparam int CTRL_RATIO_LSB = 4;
  localparam int RATIO_W = 3;

  // Status register field positions
  localparam int STAT_ENABLE_BIT = 0;
  localparam int STAT_IN_ISR_BIT = 1;
  localparam int STAT_SLOT_BIT = 2;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_SLOT_IDX_LSB = 8;

  // Reset values
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_WAKE = 1'b0;
  localparam logic RST_AFTER = 1'b0;
  localparam logic [RATIO_W-1:0] RST_RATIO = 3'h0;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;

  // Documented ratio codes
  localparam logic [RATIO_W-1:0] RATIO_1_4 = 3'h1;
  localparam logic [RATIO_W-1:0] RATIO_1_32 = 3'h4;

  // Timing
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int CLKS_PER_INSTR = 4;
  localparam int SLOT_CNT_W = 8;

  typedef struct packed {
    logic [RATIO_W-1:0] ratio;
    logic after_isr;
    logic wake;
    logic enable;
  } cthr_ctrl_type;

  typedef struct packed {
    logic osc_run;
    logic periph_tick;
    logic pmem_fetch_en;
    logic cpu_exec_en;
  } cthr_gate_type;

  typedef enum logic [2:0] {
    MODE_FULL = 3'b001,
    MODE_ACTIVE = 3'b010,
    MODE_HOLD = 3'b100
  } cthr_mode_type;

  // Last slot index of a throttle period: 2**(code+1) - 1
  function automatic logic [SLOT_CNT_W-1:0] ratio_last(
    input logic [RATIO_W-1:0] code
  );
    logic [SLOT_CNT_W:0] n;
    n = '0;
    // Index as int so code 7 reaches bit 8 instead of wrapping to bit 0
    n[int'(code) + 1] = 1'b1;
    return SLOT_CNT_W'(n - 1'b1);
  endfunction

endpackage

// File: logic/cthr_instr_div.sv
`timescale 1ns/1ns
module cthr_instr_div #(
  parameter int DIV = cthr_pkg::CLKS_PER_INSTR
) (
  clk, // System clock
  sys_rst, // Async reset, active high
  instr_tick // One-cycle pulse per instruction cycle
);
  import cthr_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  output logic instr_tick;

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] phase_reg;

  initial begin
    if (DIV < 1) begin
      $error("cthr_instr_div: DIV must be at least 1");
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_reg <= '0;
    end else if (phase_reg == LAST) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  assign instr_tick = (phase_reg == LAST);

endmodule

// File: logic/cthr_ratio_gen.sv
`timescale 1ns/1ns
module cthr_ratio_gen (
  clk, // System clock
  sys_rst, // Async reset, active high
  instr_tick, // Instruction cycle pulse
  throttle_on, // Throttling in force
  ratio_sel, // Ratio code
  slot_active, // Current instruction cycle may execute
  slot_idx // Position within the throttle period
);
  import cthr_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  input wire logic instr_tick;
  input wire logic throttle_on;
  input wire logic [RATIO_W-1:0] ratio_sel;
  output logic slot_active;
  output logic [SLOT_CNT_W-1:0] slot_idx;

  logic [SLOT_CNT_W-1:0] idx_reg;
  logic [RATIO_W-1:0] sel_seen_reg;

  // Period restarts on a ratio change so a new ratio starts active
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idx_reg <= '0;
      sel_seen_reg <= RST_RATIO;
    end else begin
      sel_seen_reg <= ratio_sel;
      if (!throttle_on || ratio_sel != sel_seen_reg) begin
        idx_reg <= '0;
      end else if (instr_tick) begin
        if (idx_reg >= ratio_last(ratio_sel)) begin
          idx_reg <= '0;
        end else begin
          idx_reg <= idx_reg + 1'b1;
        end
      end
    end
  end

  assign slot_active = (idx_reg == '0);
  assign slot_idx = idx_reg;

endmodule

// File: logic/cthr_top.sv
// Notes on behaviour
// - With throttling enabled the CPU runs one instruction cycle in N, N set by the 3-bit ratio code.
// - Ratio code 100 gives one active instruction cycle then 31 held, 1:32.
// - Ratio code 001 gives one active instruction cycle then 3 held, 1:4.
// - Peripherals keep their full-rate clocking during held cycles.
// - Only CPU and program memory are throttled; oscillators keep running.
// - Each active throttled cycle still prefetches the next instruction as normal.
// - On service routine entry the enable is copied into the after-return bit.
// - Enable set and wake bit clear: the service routine runs throttled, enable stays 1.
// - Enable set and wake bit set: enable is cleared and the routine runs at full speed.
// - Enable clear on entry: the routine runs at full speed and enable stays 0.
// - On return the enable is loaded from the after-return bit.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module cthr_top #(
  parameter int CLKS_PER_INSTR_P = cthr_pkg::CLKS_PER_INSTR
) (
  clk, // System clock
  sys_rst, // Async reset, active high
  paddr, // APB address
  psel, // APB select
  penable, // APB enable
  pwrite, // APB direction
  pwdata, // APB write data
  pstrb, // APB byte strobes
  pready, // APB ready
  prdata, // APB read data
  pslverr, // APB error
  cpu_isr_enter, // Interrupt entry pulse
  cpu_isr_return, // Return-from-interrupt pulse
  gate, // CPU, memory and peripheral enables
  throttle_active // Throttled execution in force
);
  import cthr_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  input wire logic [7:0] paddr;
  input wire logic psel;
  input wire logic penable;
  input wire logic pwrite;
  input wire logic [31:0] pwdata;
  input wire logic [3:0] pstrb;
  output logic pready;
  output logic [31:0] prdata;
  output logic pslverr;
  input wire logic cpu_isr_enter;
  input wire logic cpu_isr_return;
  output cthr_pkg::cthr_gate_type gate;
  output logic throttle_active;

  initial begin
    if (CLKS_PER_INSTR_P < 1) begin
      $error("cthr_top: CLKS_PER_INSTR_P must be at least 1");
    end
  end

  // Bus decode

  logic acc_phase;
  logic hit_ctrl;
  logic hit_status;
  logic hit_active;
  logic hit_hold;
  logic mapped;
  logic wr_fire;
  logic rd_fire;

  assign acc_phase = psel && penable;
  assign hit_ctrl = (paddr == OFS_CTRL);
  assign hit_status = (paddr == OFS_STATUS);
  assign hit_active = (paddr == OFS_ACTIVE_CNT);
  assign hit_hold = (paddr == OFS_HOLD_CNT);
  assign mapped = hit_ctrl || hit_status || hit_active || hit_hold;
  assign wr_fire = acc_phase && pwrite && mapped;
  assign rd_fire = acc_phase && !pwrite && mapped;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc_phase && !mapped;

  // Control state

  cthr_ctrl_type ctrl_reg;
  logic in_isr_reg;
  logic ctrl_wr;
  logic ctrl_wr_b0;

  // All control fields live in byte lane 0
  assign ctrl_wr = wr_fire && hit_ctrl;
  assign ctrl_wr_b0 = ctrl_wr && pstrb[0];

  // Enable: hardware interrupt events win over a same-cycle software write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg.enable <= RST_ENABLE;
    end else if (cpu_isr_enter) begin
      if (ctrl_reg.enable && ctrl_reg.wake) begin
        ctrl_reg.enable <= 1'b0;
      end else begin
        ctrl_reg.enable <= ctrl_reg.enable;
      end
    end else if (cpu_isr_return) begin
      ctrl_reg.enable <= ctrl_reg.after_isr;
    end else if (ctrl_wr_b0) begin
      ctrl_reg.enable <= pwdata[CTRL_ENABLE_BIT];
    end
  end

  // After-return bit: entry copy wins over a same-cycle software write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg.after_isr <= RST_AFTER;
    end else if (cpu_isr_enter) begin
      ctrl_reg.after_isr <= ctrl_reg.enable;
    end else if (ctrl_wr_b0) begin
      ctrl_reg.after_isr <= pwdata[CTRL_AFTER_BIT];
    end
  end

  // Software-only fields
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg.wake <= RST_WAKE;
      ctrl_reg.ratio <= RST_RATIO;
    end else if (ctrl_wr_b0) begin
      ctrl_reg.wake <= pwdata[CTRL_WAKE_BIT];
      ctrl_reg.ratio <= pwdata[CTRL_RATIO_LSB +: RATIO_W];
    end
  end

  // Service routine tracking, for status only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_isr_reg <= 1'b0;
    end else if (cpu_isr_enter) begin
      in_isr_reg <= 1'b1;
    end else if (cpu_isr_return) begin
      in_isr_reg <= 1'b0;
    end
  end

  // Instruction timing

  logic instr_tick;
  logic slot_active;
  logic [SLOT_CNT_W-1:0] slot_idx;

  cthr_instr_div #(
    .DIV(CLKS_PER_INSTR_P)
  ) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .instr_tick(instr_tick)
  );

  cthr_ratio_gen u_ratio (
    .clk(clk),
    .sys_rst(sys_rst),
    .instr_tick(instr_tick),
    .throttle_on(ctrl_reg.enable),
    .ratio_sel(ctrl_reg.ratio),
    .slot_active(slot_active),
    .slot_idx(slot_idx)
  );

  // Execution mode

  cthr_mode_type mode_reg;
  cthr_mode_type mode_next;

  always_comb begin
    if (!ctrl_reg.enable) begin
      mode_next = MODE_FULL;
    end else if (slot_active) begin
      mode_next = MODE_ACTIVE;
    end else begin
      mode_next = MODE_HOLD;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= MODE_FULL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Gating outputs

  logic exec_ok;
  logic tick_d_reg;

  // Follows the registered mode, so delay the tick to stay aligned
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= instr_tick;
    end
  end

  always_comb begin
    unique case (mode_reg)
      MODE_FULL: exec_ok = 1'b1;
      MODE_ACTIVE: exec_ok = 1'b1;
      MODE_HOLD: exec_ok = 1'b0;
      default: exec_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gate <= '0;
    end else begin
      gate.cpu_exec_en <= tick_d_reg && exec_ok;
      gate.pmem_fetch_en <= tick_d_reg && exec_ok;
      gate.periph_tick <= tick_d_reg;
      gate.osc_run <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      throttle_active <= 1'b0;
    end else begin
      throttle_active <= (mode_reg != MODE_FULL);
    end
  end

  // Cycle counters

  logic [31:0] active_cnt_reg;
  logic [31:0] hold_cnt_reg;
  logic active_clr;
  logic hold_clr;

  // Any write clears; a count in the clearing cycle is dropped
  assign active_clr = wr_fire && hit_active;
  assign hold_clr = wr_fire && hit_hold;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_cnt_reg <= RST_COUNT;
    end else if (active_clr) begin
      active_cnt_reg <= RST_COUNT;
    end else if (tick_d_reg && mode_reg == MODE_ACTIVE) begin
      active_cnt_reg <= active_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_cnt_reg <= RST_COUNT;
    end else if (hold_clr) begin
      hold_cnt_reg <= RST_COUNT;
    end else if (tick_d_reg && mode_reg == MODE_HOLD) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
    end
  end

  // Read path

  logic [31:0] rd_mux;
  logic [31:0] ctrl_view;
  logic [31:0] stat_view;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[CTRL_ENABLE_BIT] = ctrl_reg.enable;
    ctrl_view[CTRL_WAKE_BIT] = ctrl_reg.wake;
    ctrl_view[CTRL_AFTER_BIT] = ctrl_reg.after_isr;
    ctrl_view[CTRL_RATIO_LSB +: RATIO_W] = ctrl_reg.ratio;
  end

  always_comb begin
    stat_view = '0;
    stat_view[STAT_ENABLE_BIT] = throttle_active;
    stat_view[STAT_IN_ISR_BIT] = in_isr_reg;
    stat_view[STAT_SLOT_BIT] = slot_active;
    stat_view[STAT_MODE_LSB +: 3] = mode_reg;
    stat_view[STAT_SLOT_IDX_LSB +: SLOT_CNT_W] = slot_idx;
  end

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux = ctrl_view;
    end else if (hit_status) begin
      rd_mux = stat_view;
    end else if (hit_active) begin
      rd_mux = active_cnt_reg;
    end else if (hit_hold) begin
      rd_mux = hold_cnt_reg;
    end
  end

  // Registered read data, held until the next read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end else if (rd_fire) begin
      prdata <= prdata;
    end
  end

endmodule

// File: dv/cthr_top_sva.sv
`timescale 1ns/1ns
module cthr_top_sva #(
  parameter int CLKS_PER_INSTR_P = 4
) (
  clk, // System clock
  sys_rst, // Async reset
  gate, // Gating outputs
  throttle_active // Throttle level
);
  import cthr_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  input wire cthr_pkg::cthr_gate_type gate;
  input wire logic throttle_active;
  logic [8:0] held_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Held instruction cycles since the last executed one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      held_cnt <= '0;
    end else if (gate.cpu_exec_en || !throttle_active) begin
      held_cnt <= '0;
    end else if (gate.periph_tick) begin
      held_cnt <= held_cnt + 9'h001;
    end
  end
  sequence s_quiet3;
    !gate.cpu_exec_en [*3];
  endsequence
  // A drop out of throttling may legally bring the next pulse sooner
  sequence s_quiet7;
    (!gate.cpu_exec_en || !throttle_active) [*7];
  endsequence
  AST_OSC_RUN: assert property (!$past(sys_rst) |-> gate.osc_run)
    else $error("oscillator enable dropped");
  AST_TICK_PERIOD: assert property (gate.periph_tick |->
    ##CLKS_PER_INSTR_P gate.periph_tick)
    else $error("peripheral tick missed");
  AST_TICK_PULSE: assert property (gate.periph_tick |=>
    !gate.periph_tick)
    else $error("peripheral tick too long");
  AST_FETCH_EXEC: assert property (
    gate.pmem_fetch_en == gate.cpu_exec_en)
    else $error("fetch differs from execute");
  AST_EXEC_SPACE: assert property (gate.cpu_exec_en |=> s_quiet3)
    else $error("execute pulses too close");
  AST_THR_GAP: assert property (throttle_active && $past(throttle_active, 3)
    && gate.cpu_exec_en |=> s_quiet7)
    else $error("throttled execute too soon");
  AST_HOLD_BOUND: assert property (held_cnt < 9'h100)
    else $error("held too long");
  AST_RESUME: assert property ($fell(throttle_active) |->
    ##[1:12] gate.cpu_exec_en)
    else $error("no full speed after throttle off");
endmodule

// File: dv/cthr_cpu_model.sv
`timescale 1ns/1ns
module cthr_cpu_model (
  clk, // System clock
  gate, // Gating from the block
  isr_enter, // Entry pulse
  isr_return // Return pulse
);
  import cthr_pkg::*;
  input wire logic clk;
  input wire cthr_pkg::cthr_gate_type gate;
  output logic isr_enter;
  output logic isr_return;
  initial begin
    isr_enter = 1'b0;
    isr_return = 1'b0;
  end
  task automatic event_pulse(input logic ret);
    @(posedge clk);
    isr_return <= ret;
    isr_enter <= !ret;
    @(posedge clk);
    isr_enter <= 1'b0;
    isr_return <= 1'b0;
  endtask
  // Sampled on the falling edge so registered outputs have settled
  task automatic exec_gap(output int n);
    int k;
    n = 0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!gate.cpu_exec_en && k < 3000);
    do begin
      @(negedge clk);
      k++;
      n += gate.periph_tick;
    end while (!gate.cpu_exec_en && k < 3000);
    if (k >= 3000) n = -1;
  endtask
endmodule

// File: dv/cpu_throttle_control_tb.sv
`timescale 1ns/1ns
module cpu_throttle_control_tb;
  import cthr_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic isr_enter, isr_return, throttle_active;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rd, ctl;
  cthr_gate_type gate;
  int fail_count, compares, n;
  cthr_top #(.CLKS_PER_INSTR_P(4)) i_cthr_top (.clk(clk), .sys_rst(sys_rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cpu_isr_enter(isr_enter),
    .cpu_isr_return(isr_return), .gate(gate),
    .throttle_active(throttle_active));
  cthr_cpu_model i_cthr_cpu_model (.clk(clk), .gate(gate),
    .isr_enter(isr_enter), .isr_return(isr_return));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic finish_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    psel <= 1'b0;
  endtask
  initial begin
    #10_000_000;
    fail_count++;
    finish_test;
  end
  initial begin
    sys_rst = 1'b1;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    apb(8'h10, 1'b0, 32'h0);
    check(32'(err), 32'h1);
    i_cthr_cpu_model.exec_gap(n);
    check(32'(n), 32'h1);
    for (int c = 0; c < 8; c++) begin
      apb(OFS_CTRL, 1'b1, 32'(c) << CTRL_RATIO_LSB | 32'h1);
      i_cthr_cpu_model.exec_gap(n);
      i_cthr_cpu_model.exec_gap(n);
      check(32'(n), 32'h1 << (c + 1));
      apb(OFS_CTRL, 1'b1, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      ctl = 32'h10 | 32'(i) | {29'h0, !i[0], 2'h0};
      apb(OFS_CTRL, 1'b1, ctl);
      i_cthr_cpu_model.event_pulse(1'b0);
      apb(OFS_STATUS, 1'b0, 32'h0);
      check(32'(rd[STAT_IN_ISR_BIT]), 32'h1);
      apb(OFS_CTRL, 1'b0, 32'h0);
      check(rd, {25'h0, 3'h1, 1'b0, i[0], i[1], i[0] & !i[1]});
      check(32'(throttle_active), 32'(i[0] & !i[1]));
      apb(OFS_CTRL, 1'b1, rd ^ 32'h4);
      i_cthr_cpu_model.event_pulse(1'b1);
      apb(OFS_CTRL, 1'b0, 32'h0);
      check(32'(rd[0]), 32'(!i[0]));
      check(32'(throttle_active), 32'(!i[0]));
    end
    finish_test;
  end
endmodule
bind cthr_top cthr_top_sva #(.CLKS_PER_INSTR_P(CLKS_PER_INSTR_P))
  i_cthr_top_sva (.clk(clk), .sys_rst(sys_rst), .gate(gate),
  .throttle_active(throttle_active));
